/* coitc_cam_output.sv */
// cam switching logic with dynamic idle-time compensation and overload shutdown.
// assumes position, cam table and overload inputs synchronous to i_mclk.
// Operation
// - every control cycle recompute required advance from current speed
// - path mode: applied advance moves at most one increment per position change
// - path mode: applied advance frozen at standstill
// - timed mode: applied advance moves at most one increment per control cycle
// - direct mode: required advance copied unchanged each control cycle
// - without compensation a one-increment cam is still detected and set
// - above max speed n-fold, shortest reliable cam grows to n increments
// - switching delay one full control cycle (output uses position sampled at previous tick); sampling jitter below one control cycle
// - speed sampled at fixed interval, one millisecond
// - compensation period in ms equals highest compensated output index plus one
// - sustained overload switches affected outputs off and reports error
// - blockwise: one advance per group of eight outputs; bitwise per output
`timescale 1ns/1ps
`default_nettype none

module coitc_cam_output
	import coitc_pkg::*;
#(
	parameter int SPEED_SAMPLE_CYCLES = SPEED_CYCLES
)(
	input  wire logic                       i_mclk,
	input  wire logic                       i_reset_n,
	input  wire logic [POS_W-1:0]           i_position,
	input  wire logic [POS_W-1:0]           i_zero_offset,
	input  wire coitc_mode_t                i_mode,
	input  wire logic                       i_bitwise,
	input  wire coitc_cam_t [NUM_OUT-1:0]   i_cam,
	input  wire logic [NUM_OUT-1:0]         i_overload,
	input  wire logic                       i_error_ack,
	output logic      [NUM_OUT-1:0]         o_outputs,
	output logic      [NUM_OUT-1:0]         o_tripped,
	output logic                            o_error,
	output logic      [POS_W-1:0]           o_speed,
	output logic                            o_cycle_tick
);
	localparam int TICK_W = $clog2(CTRL_CYCLES);
	localparam int SMP_W  = $clog2(SPEED_SAMPLE_CYCLES + 1);
	localparam int OVL_W  = $clog2(OVL_LIMIT + 1);

	function automatic logic cam_hit(input logic [POS_W-1:0] pos,
	                                 input logic [POS_W-1:0] on_p,
	                                 input logic [POS_W-1:0] off_p);
		if (on_p <= off_p) begin
			cam_hit = (pos >= on_p) && (pos <= off_p);
		end else begin
			cam_hit = (pos >= on_p) || (pos <= off_p);
		end
	endfunction

	function automatic logic [ADV_W-1:0] calc_adv(input logic [POS_W-1:0]  spd,
	                                            input logic [IDLE_W-1:0] idle);
		logic [21:0] prod;
		logic [37:0] scaled;
		prod   = 22'(spd) * 22'(idle);
		scaled = 38'(prod) * 38'(DIV10_MULT);
		if (scaled[37:16] > 22'(ADV_MAX)) begin
			calc_adv = ADV_MAX;
		end else begin
			calc_adv = scaled[16+ADV_W-1:16];
		end
	endfunction

	// timing state
	logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
	logic [SMP_W-1:0]  smp_cnt_reg, smp_cnt_next;
	logic [4:0]        ms_cnt_reg, ms_cnt_next;
	logic              tick, ms_strobe;
	logic              ms_valid_reg, ms_valid_next;

	// position and speed state
	logic [POS_W-1:0] pos_reg, pos_next;
	logic [POS_W-1:0] ms_pos_reg, ms_pos_next;
	logic [POS_W-1:0] speed_reg, speed_next;
	logic             pos_moved;
	logic [POS_W-1:0] corr_pos, delta;
	logic [4:0]       period_ms;

	// output state
	logic [NUM_OUT-1:0] out_reg, out_next;
	logic [NUM_OUT-1:0] trip_reg, trip_next;
	logic               err_reg, err_next;
	logic [OVL_W-1:0]   ovl_cnt_reg  [NUM_OUT];
	logic [OVL_W-1:0]   ovl_cnt_next [NUM_OUT];

	logic [ADV_W-1:0] required [NUM_OUT];
	logic [ADV_W-1:0] applied  [NUM_OUT];

	assign tick      = (tick_cnt_reg == TICK_W'(CTRL_CYCLES - 1));
	assign ms_strobe = (smp_cnt_reg == SMP_W'(SPEED_SAMPLE_CYCLES - 1));
	assign corr_pos  = i_position - i_zero_offset;
	assign delta     = corr_pos - ms_pos_reg;

	// highest compensated output, one-based
	always_comb begin
		period_ms = 5'h00;
		for (int k = 0; k < NUM_OUT; k++) begin
			if (i_cam[k].idle_time != '0) begin
				period_ms = 5'(k + 1);
			end
		end
	end

	always_comb begin
		tick_cnt_next = tick ? '0 : tick_cnt_reg + TICK_W'(1);
		smp_cnt_next  = ms_strobe ? '0 : smp_cnt_reg + SMP_W'(1);
		ms_cnt_next   = ms_cnt_reg;
		ms_pos_next   = ms_pos_reg;
		ms_valid_next = ms_valid_reg;
		speed_next    = speed_reg;
		if (ms_strobe) begin
			ms_pos_next   = corr_pos;
			ms_valid_next = 1'b1;
			if (ms_cnt_reg + 5'h01 >= period_ms) begin
				ms_cnt_next = 5'h00;
				// first sample after reset has no predecessor to diff against
				if ((period_ms != 5'h00) && ms_valid_reg) begin
					// magnitude of 1 ms position change
					speed_next = delta[POS_W-1] ? (POS_W'(0) - delta) : delta;
				end
			end else begin
				ms_cnt_next = ms_cnt_reg + 5'h01;
			end
		end
	end

	always_comb begin
		pos_next  = pos_reg;
		pos_moved = 1'b0;
		if (tick) begin
			pos_next  = corr_pos;
			pos_moved = (corr_pos != pos_reg);
		end
	end

	// required advance per output, blockwise or bitwise
	always_comb begin
		for (int k = 0; k < NUM_OUT; k++) begin
			if (i_cam[k].idle_time == '0) begin
				required[k] = ADV_RESET;
			end else if (i_bitwise) begin
				required[k] = calc_adv(speed_reg, i_cam[k].idle_time);
			end else begin
				required[k] = calc_adv(speed_reg, i_cam[(k / BLOCK_SIZE) * BLOCK_SIZE].idle_time);
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_OUT; g++) begin : g_slew
			coitc_advance_slew u_slew (
				.i_mclk      (i_mclk),
				.i_reset_n   (i_reset_n),
				.i_tick      (tick),
				.i_pos_moved (pos_moved),
				.i_mode      (i_mode),
				.i_required  (required[g]),
				.o_applied   (applied[g])
			);
		end
	endgenerate

	always_comb begin
		out_next  = out_reg;
		trip_next = trip_reg;
		err_next  = err_reg;
		if (i_error_ack) begin
			trip_next = '0;
			err_next  = 1'b0;
		end
		for (int k = 0; k < NUM_OUT; k++) begin
			ovl_cnt_next[k] = ovl_cnt_reg[k];
			if (tick) begin
				if (!i_overload[k]) begin
					ovl_cnt_next[k] = '0;
				end else if (ovl_cnt_reg[k] == OVL_W'(OVL_LIMIT - 1)) begin
					ovl_cnt_next[k] = '0;
					trip_next[k]    = 1'b1;
					err_next        = 1'b1;
				end else begin
					ovl_cnt_next[k] = ovl_cnt_reg[k] + OVL_W'(1);
				end
				// shifted position, one increment cams caught each cycle
				out_next[k] = cam_hit(pos_reg + POS_W'(applied[k]),
				                      i_cam[k].on_pos, i_cam[k].off_pos) && !trip_next[k];
			end else if (trip_next[k]) begin
				out_next[k] = 1'b0;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tick_cnt_reg <= '0;
			smp_cnt_reg  <= '0;
			ms_cnt_reg   <= 5'h00;
			ms_pos_reg   <= POS_RESET;
			ms_valid_reg <= 1'b0;
			speed_reg    <= POS_RESET;
			pos_reg      <= POS_RESET;
			out_reg      <= '0;
			trip_reg     <= '0;
			err_reg      <= 1'b0;
			for (int k = 0; k < NUM_OUT; k++) begin
				ovl_cnt_reg[k] <= '0;
			end
		end else begin
			tick_cnt_reg <= tick_cnt_next;
			smp_cnt_reg  <= smp_cnt_next;
			ms_cnt_reg   <= ms_cnt_next;
			ms_pos_reg   <= ms_pos_next;
			ms_valid_reg <= ms_valid_next;
			speed_reg    <= speed_next;
			pos_reg      <= pos_next;
			out_reg      <= out_next;
			trip_reg     <= trip_next;
			err_reg      <= err_next;
			for (int k = 0; k < NUM_OUT; k++) begin
				ovl_cnt_reg[k] <= ovl_cnt_next[k];
			end
		end
	end

	assign o_outputs    = out_reg;
	assign o_tripped    = trip_reg;
	assign o_error      = err_reg;
	assign o_speed      = speed_reg;
	assign o_cycle_tick = tick;
endmodule

`default_nettype wire

/* coitc_advance_slew.sv */
// coitc_pkg: shared constants and types of the cam output block.
// coitc_advance_slew: moves one output's applied advance toward its required value.
// assumes one clock, i_mclk, with asynchronous active-low reset i_reset_n.
`timescale 1ns/1ps
`default_nettype none

package coitc_pkg;
	localparam int          NUM_OUT        = 16;
	localparam int          BLOCK_SIZE     = 8;
	localparam int          POS_W          = 12;
	localparam int          IDLE_W         = 10;
	localparam int          ADV_W          = 11;
	localparam int          CLK_FREQ_HZ    = 10_000_000;
	localparam int          CTRL_CYCLE_NS  = 100_000;
	localparam int          CTRL_CYCLES    = (CTRL_CYCLE_NS * (CLK_FREQ_HZ / 1_000_000)) / 1000;
	localparam int          SPEED_SAMPLE_US = 1000;
	localparam int          SPEED_CYCLES   = SPEED_SAMPLE_US * (CLK_FREQ_HZ / 1_000_000);
	localparam int          OVL_LIMIT      = 8;
	localparam logic [15:0] DIV10_MULT     = 16'h199a;
	localparam logic [POS_W-1:0]  POS_RESET = 12'h000;
	localparam logic [ADV_W-1:0]  ADV_RESET = 11'h000;
	localparam logic [ADV_W-1:0]  ADV_MAX   = 11'h7ff;

	typedef enum logic [1:0] {
		COITC_PATH   = 2'b00,
		COITC_TIMED  = 2'b01,
		COITC_DIRECT = 2'b10
	} coitc_mode_t;

	typedef struct packed {
		logic [POS_W-1:0]  on_pos;
		logic [POS_W-1:0]  off_pos;
		logic [IDLE_W-1:0] idle_time;
	} coitc_cam_t;
endpackage

module coitc_advance_slew
	import coitc_pkg::*;
(
	input  wire logic             i_mclk,
	input  wire logic             i_reset_n,
	input  wire logic             i_tick,
	input  wire logic             i_pos_moved,
	input  wire coitc_mode_t      i_mode,
	input  wire logic [ADV_W-1:0] i_required,
	output logic      [ADV_W-1:0] o_applied
);
	logic [ADV_W-1:0] applied_reg;
	logic [ADV_W-1:0] applied_next;
	logic [ADV_W-1:0] step_val;

	always_comb begin
		if (i_required > applied_reg) begin
			step_val = applied_reg + 11'h001;
		end else if (i_required < applied_reg) begin
			step_val = applied_reg - 11'h001;
		end else begin
			step_val = applied_reg;
		end
		applied_next = applied_reg;
		if (i_tick) begin
			case (i_mode)
				COITC_PATH: begin
					// standstill: advance left frozen
					if (i_pos_moved) begin
						applied_next = step_val;
					end
				end
				COITC_TIMED:  applied_next = step_val;
				COITC_DIRECT: applied_next = i_required;
				default:      applied_next = applied_reg;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			applied_reg <= ADV_RESET;
		end else begin
			applied_reg <= applied_next;
		end
	end

	assign o_applied = applied_reg;
endmodule

`default_nettype wire

/* coitc_cam_output_sva.sv */
// checker on the cam output block ports
// assumes binding to coitc_cam_output, single clock domain
`timescale 1ns/1ps
`default_nettype none
module coitc_cam_output_sva
	import coitc_pkg::*;
(
	input wire logic               i_mclk,
	input wire logic               i_reset_n,
	input wire logic [NUM_OUT-1:0] i_overload,
	input wire logic               i_error_ack,
	input wire logic [NUM_OUT-1:0] o_outputs,
	input wire logic [NUM_OUT-1:0] o_tripped,
	input wire logic               o_error,
	input wire logic               o_cycle_tick
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	sequence s_quiet;
		!o_cycle_tick [*8];
	endsequence
	sequence s_new_trip;
		(o_tripped & ~$past(o_tripped)) != '0;
	endsequence
	property p_tick_gap;
		o_cycle_tick |=> s_quiet;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("tick repeats early");
	property p_out_rise;
		(o_outputs & ~$past(o_outputs)) != '0 |-> $past(o_cycle_tick);
	endproperty
	a_out_rise: assert property (p_out_rise) else $error("output set off tick");
	property p_trip_cause;
		s_new_trip |-> $past(o_cycle_tick)
			&& ((o_tripped & ~$past(o_tripped) & ~$past(i_overload)) == '0);
	endproperty
	a_trip_cause: assert property (p_trip_cause) else $error("trip without overload");
	property p_trip_off;
		!$past(i_error_ack) |-> (o_outputs & $past(o_tripped)) == '0;
	endproperty
	a_trip_off: assert property (p_trip_off) else $error("tripped output on");
	property p_trip_err;
		|o_tripped |-> o_error;
	endproperty
	a_trip_err: assert property (p_trip_err) else $error("trip not reported");
	property p_err_hold;
		o_error && !i_error_ack |=> o_error;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error dropped");
	property p_ack;
		i_error_ack && !o_cycle_tick |=> !o_error && o_tripped == '0;
	endproperty
	a_ack: assert property (p_ack) else $error("ack ignored");
	property p_err_rise;
		$rose(o_error) |-> $past(o_cycle_tick);
	endproperty
	a_err_rise: assert property (p_err_rise) else $error("error off tick");
endmodule
bind coitc_cam_output coitc_cam_output_sva u_sva (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
	.i_overload(i_overload), .i_error_ack(i_error_ack), .o_outputs(o_outputs),
	.o_tripped(o_tripped), .o_error(o_error), .o_cycle_tick(o_cycle_tick));
`default_nettype wire

/* coitc_encoder_model.sv */
// absolute encoder model stepping once per control cycle
// assumes i_tick is the block's cycle tick on i_mclk
`timescale 1ns/1ps
`default_nettype none
module coitc_encoder_model
	import coitc_pkg::*;
#(
	parameter logic [POS_W-1:0] START = 12'h2f8
)(
	input  wire logic             i_mclk,
	input  wire logic             i_reset_n,
	input  wire logic             i_tick,
	input  wire logic [POS_W-1:0] i_step,
	output logic      [POS_W-1:0] o_position
);
	// moves only on tick edges so speed per ms is exact
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) o_position <= START;
		else if (i_tick) o_position <= o_position + i_step;
	end
endmodule
`default_nettype wire

/* coitc_cam_output_tb.sv */
// self-checking bench for the cam output block
// assumes encoder model at 10 increments per control cycle
`timescale 1ns/1ps
`default_nettype none
module coitc_cam_output_tb
	import coitc_pkg::*;
;
	logic                     clk = 1'b0, rst_n = 1'b0, bw = 1'b1, ack = 1'b0, tick, err;
	coitc_mode_t              mode = COITC_PATH;
	coitc_cam_t [NUM_OUT-1:0] cam;
	logic [NUM_OUT-1:0]       ovl = '0, outs, trip;
	logic [POS_W-1:0]         pos, speed;
	logic [POS_W-1:0]         zoff = 12'h000;
	int                       n_mismatch = 0, samples_checked = 0;
	always #50 clk = ~clk;
	coitc_encoder_model enc (.i_mclk(clk), .i_reset_n(rst_n), .i_tick(tick),
		.i_step(12'h00a), .o_position(pos));
	coitc_cam_output #(.SPEED_SAMPLE_CYCLES(2000)) dut (.i_mclk(clk), .i_reset_n(rst_n),
		.i_position(pos), .i_zero_offset(zoff), .i_mode(mode), .i_bitwise(bw),
		.i_cam(cam), .i_overload(ovl), .i_error_ack(ack), .o_outputs(outs),
		.o_tripped(trip), .o_error(err), .o_speed(speed), .o_cycle_tick(tick));
	task check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task ticks(input int n);
		repeat (n) @(posedge clk iff tick === 1'b1);
		#2;
	endtask
	// reset, then 9 cycles: position 830 less offset, speed 20, slewed advance 4
	task run_mode(input coitc_mode_t m, input logic b, input logic [POS_W-1:0] off,
		input logic [15:0] exp);
		rst_n = 1'b0;
		zoff = off;
		mode = m;
		bw = b;
		repeat (12) @(posedge clk);
		#2 rst_n = 1'b1;
		ticks(9);
		check(outs & 16'h0003, exp);
		check({4'h0, speed}, 16'h0014);
	endtask
	task t_slewed;
		run_mode(COITC_PATH, 1'b1, 12'h000, 16'h0002);
		run_mode(COITC_TIMED, 1'b1, 12'h000, 16'h0002);
	endtask
	task t_direct;
		run_mode(COITC_DIRECT, 1'b1, 12'h000, 16'h0003);
		run_mode(COITC_DIRECT, 1'b0, 12'h000, 16'h0001);
		run_mode(COITC_DIRECT, 1'b1, 12'h0c8, 16'h0000);
	endtask
	// seven loaded cycles must not trip, eight must
	task t_overload;
		ovl[2] = 1'b1;
		ticks(7);
		check(outs & 16'h000c, 16'h000c);
		ovl = '0;
		ticks(1);
		check(trip, 16'h0000);
		ovl[2] = 1'b1;
		ticks(8);
		check(trip, 16'h0004);
		check({15'h0, err}, 16'h0001);
		check(outs & 16'h000c, 16'h0008);
		ovl = '0;
		ack = 1'b1;
		@(posedge clk);
		#2 ack = 1'b0;
		check({trip[14:0], err}, 16'h0000);
	endtask
	task final_report;
		if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		cam = '0;
		cam[0] = '{12'h3e8, 12'h44c, 10'h064};
		cam[1] = '{12'h342, 12'h3a2, 10'h032};
		cam[2] = '{12'h000, 12'hfff, 10'h000};
		cam[3] = cam[2];
		t_slewed;
		t_direct;
		t_overload;
		final_report;
	end
	initial begin
		#9_000_000;
		n_mismatch++;
		final_report;
	end
endmodule
`default_nettype wire
